// *** pkg/mid_map.svh ***
// Constant map: register offsets, bit positions and reset values of the execution block
`ifndef MID_MAP_SVH
`define MID_MAP_SVH
// ****************************************
// Register offsets on the plain register port
// ****************************************
`define MID_REG_WORKING 3'h0
`define MID_REG_TBL_HIGH 3'h1
`define MID_REG_CONTROL 3'h2
`define MID_REG_STATUS 3'h3
`define MID_REG_PC_LOW 3'h4
`define MID_REG_PC_HIGH 3'h5
// ****************************************
// Field positions
// ****************************************
`define MID_CTRL_IRQ_EN_BIT 0
`define MID_STAT_NULL_BIT 0
`define MID_STAT_BUSY_BIT 1
`define MID_TBL_PC_MSB 1
// ****************************************
// Reset values and arithmetic constants
// ****************************************
`define MID_RST_BYTE 8'h00
`define MID_RST_PC 10'h000
`define MID_RST_IRQ_EN 1'b0
`define MID_RST_FILE_ADDR 6'h00
`define MID_ONE 8'h01
`define MID_DEST_FILE 1'b1
`endif

// *** pkg/mid_pkg.sv ***
// Types shared by the execution block: operation codes and sequencing states
`default_nettype none
package mid_pkg;
  // Operations that this block executes
  typedef enum logic [2:0] {
    MID_NOP_OP = 3'h0,
    MID_SUB_ONE_OP = 3'h1,
    MID_ADD_ONE_OP = 3'h2,
    MID_ADD_ONE_SKIP_NULL_OP = 3'h3,
    MID_IRQ_GLOBAL_OFF_OP = 3'h4,
    MID_IRQ_GLOBAL_ON_OP = 3'h5,
    MID_JUMP_VIA_WORKING_REG_OP = 3'h6
  } mid_op_t;
  // Sequencer: one Gray step into the second cycle and back
  typedef enum logic {
    MID_ST_ISSUE = 1'b0,
    MID_ST_SECOND = 1'b1
  } mid_state_t;
endpackage
`default_nettype wire

// *** src/mid_exec.sv ***
// Execution unit for step, skip, global interrupt enable and indirect jump operations
`timescale 1ns/1ps
`default_nettype none
`include "mid_map.svh"
// What this block does
// [RL1] Subtract one from file, route by destination bit
// [RL2] Add one to file, route by destination bit
// [RL3] Add-one-skip increments, routes, tests for zero
// [RL4] Zero result discards next fetch, two cycles
// [RL5] Global interrupt off clears enable, one cycle
// [RL6] Global interrupt on sets enable, one cycle
// [RL7] Jump loads PC from table pointer, working
// [RL8] Jump always branches, two cycles, no flags
// [RL9] Steps wrap modulo 256; null flag tracks zero
module mid_exec (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic instr_valid, // Operation offered this cycle
  input wire mid_pkg::mid_op_t instr_op, // Which operation
  input wire logic instr_dest, // Destination bit: 0 working, 1 file
  input wire logic [5:0] file_addr, // Addressed file register
  input wire logic [7:0] file_data, // Current content of that register
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic instr_ready, // High when an operation may be taken
  output logic file_wr, // One-cycle write-back pulse
  output logic [5:0] file_wr_addr,
  output logic [7:0] file_wr_data,
  output logic fetch_discard, // One-cycle pulse: drop fetched word
  output logic pc_load, // One-cycle pulse: take pc_value
  output logic [9:0] pc_value,
  output logic global_irq_enable,
  output logic null_flag
);
  // ****************************************
  // Datapath helpers
  // ****************************************
  // Step by one, wrapping on the 8-bit path
  function automatic logic [7:0] mid_step(input logic [7:0] v, input logic up);
    mid_step = up ? v + `MID_ONE : v - `MID_ONE; // [RL9]
  endfunction

  logic [7:0] working_reg; // Accumulator
  logic [7:0] table_high_pointer; // Upper jump address source
  mid_pkg::mid_state_t state; // Sequencer state
  logic take; // Operation accepted this cycle
  logic is_step; // One of the three step operations
  logic [7:0] step_res; // Result of the step
  logic next_null; // Zero test of the step result

  assign take = instr_valid && instr_ready;
  assign is_step = (instr_op == mid_pkg::MID_SUB_ONE_OP) || (instr_op == mid_pkg::MID_ADD_ONE_OP) ||
                   (instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP);
  assign step_res = mid_step(file_data, instr_op != mid_pkg::MID_SUB_ONE_OP); // [RL1] [RL2] [RL3]
  assign next_null = (step_res == `MID_RST_BYTE); // [RL9]

  // ****************************************
  // Sequencer
  // ****************************************
  // Two-cycle operations hold off the next issue for one cycle
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= mid_pkg::MID_ST_ISSUE;
      instr_ready <= 1'b1;
    end else begin
      unique case (state)
        mid_pkg::MID_ST_ISSUE: begin
          if (take && ((instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP) ||
              (instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP && next_null))) begin
            state <= mid_pkg::MID_ST_SECOND; // [RL4] [RL8]
            instr_ready <= 1'b0;
          end
        end
        mid_pkg::MID_ST_SECOND: begin
          // Slot of the discarded word runs as a no-operation
          state <= mid_pkg::MID_ST_ISSUE;
          instr_ready <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // Program flow pulses
  // ****************************************
  // Discard and jump pulses appear in the cycle after issue
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      fetch_discard <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= `MID_RST_PC;
    end else begin
      fetch_discard <= take && (instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP) && next_null; // [RL4]
      pc_load <= take && (instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP); // [RL8]
      if (take && instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP) begin
        pc_value <= {table_high_pointer[`MID_TBL_PC_MSB:0], working_reg}; // [RL7]
      end
    end
  end

  // ****************************************
  // File register write-back
  // ****************************************
  // Destination bit 1 writes the step result back to the file
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      file_wr <= 1'b0;
      file_wr_addr <= `MID_RST_FILE_ADDR;
      file_wr_data <= `MID_RST_BYTE;
    end else begin
      file_wr <= take && is_step && (instr_dest == `MID_DEST_FILE); // [RL1] [RL2] [RL3]
      if (take && is_step) begin
        file_wr_addr <= file_addr;
        file_wr_data <= step_res;
      end
    end
  end

  // ****************************************
  // Working register and table pointer
  // ****************************************
  // An operation in the same cycle as a software write wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      working_reg <= `MID_RST_BYTE;
    end else if (take && is_step && (instr_dest != `MID_DEST_FILE)) begin
      working_reg <= step_res; // [RL1] [RL2] [RL3]
    end else if (reg_wr && reg_addr == `MID_REG_WORKING) begin
      working_reg <= reg_wdata;
    end
  end

  // Only software loads the table pointer
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      table_high_pointer <= `MID_RST_BYTE;
    end else if (reg_wr && reg_addr == `MID_REG_TBL_HIGH) begin
      table_high_pointer <= reg_wdata;
    end
  end

  // ****************************************
  // Flags
  // ****************************************
  // Null flag follows only the step operations; others leave it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      null_flag <= 1'b0;
    end else if (take && is_step) begin
      null_flag <= next_null; // [RL9]
    end else if (reg_wr && reg_addr == `MID_REG_STATUS) begin
      null_flag <= reg_wdata[`MID_STAT_NULL_BIT];
    end
  end

  // Global enable: operations win over a software write
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      global_irq_enable <= `MID_RST_IRQ_EN;
    end else if (take && instr_op == mid_pkg::MID_IRQ_GLOBAL_OFF_OP) begin
      global_irq_enable <= 1'b0; // [RL5]
    end else if (take && instr_op == mid_pkg::MID_IRQ_GLOBAL_ON_OP) begin
      global_irq_enable <= 1'b1; // [RL6]
    end else if (reg_wr && reg_addr == `MID_REG_CONTROL) begin
      global_irq_enable <= reg_wdata[`MID_CTRL_IRQ_EN_BIT];
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `MID_RST_BYTE;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `MID_REG_WORKING: reg_rdata <= working_reg;
        `MID_REG_TBL_HIGH: reg_rdata <= table_high_pointer;
        `MID_REG_CONTROL: reg_rdata <= {7'h00, global_irq_enable};
        `MID_REG_STATUS: reg_rdata <= {6'h00, !instr_ready, null_flag};
        `MID_REG_PC_LOW: reg_rdata <= pc_value[7:0];
        `MID_REG_PC_HIGH: reg_rdata <= {6'h00, pc_value[9:8]};
        default: reg_rdata <= `MID_RST_BYTE; // Unmapped reads zero
      endcase
    end else begin
      reg_rdata <= `MID_RST_BYTE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking mid_cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sub_one_result_a: assert property ( // [RL1]
    take && instr_op == mid_pkg::MID_SUB_ONE_OP && instr_dest |=> file_wr && file_wr_data == $past(file_data) - 8'h01)
    else $error("decrement write-back wrong");
  add_one_working_a: assert property ( // [RL2]
    take && instr_op == mid_pkg::MID_ADD_ONE_OP && !instr_dest |=> !file_wr && working_reg == $past(file_data) + 8'h01)
    else $error("increment to working register wrong");
  skip_route_a: assert property ( // [RL3]
    take && instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP |=> file_wr == $past(instr_dest))
    else $error("skip increment routed wrong");
  skip_two_cycle_a: assert property ( // [RL4]
    take && instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP && file_data == 8'hff |=> fetch_discard && !instr_ready ##1 instr_ready)
    else $error("zero skip not two cycles");
  no_skip_a: assert property ( // [RL4]
    take && instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP && file_data != 8'hff |=> !fetch_discard && instr_ready)
    else $error("skip taken without zero");
  irq_off_a: assert property ( // [RL5]
    take && instr_op == mid_pkg::MID_IRQ_GLOBAL_OFF_OP |=> !global_irq_enable && $stable(null_flag))
    else $error("global off failed");
  irq_on_a: assert property ( // [RL6]
    take && instr_op == mid_pkg::MID_IRQ_GLOBAL_ON_OP |=> global_irq_enable && $stable(null_flag))
    else $error("global on failed");
  jump_target_a: assert property ( // [RL7]
    take && instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP |=>
      pc_value == {$past(table_high_pointer[1:0]), $past(working_reg)})
    else $error("jump target wrong");
  jump_timing_a: assert property ( // [RL8]
    take && instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP |=> pc_load && !instr_ready && $stable(null_flag) ##1 instr_ready)
    else $error("jump not two cycles");
  null_flag_a: assert property ( // [RL9]
    take && is_step && !reg_wr |=> null_flag == ($past(step_res) == 8'h00))
    else $error("null flag wrong");

  skip_taken_c: cover property (take && instr_op == mid_pkg::MID_ADD_ONE_SKIP_NULL_OP ##1 fetch_discard);
  jump_taken_c: cover property (take && instr_op == mid_pkg::MID_JUMP_VIA_WORKING_REG_OP ##1 pc_load);
  wrap_down_c: cover property (take && instr_op == mid_pkg::MID_SUB_ONE_OP && file_data == 8'h00);
  irq_toggle_c: cover property (global_irq_enable ##1 !global_irq_enable ##1 global_irq_enable);
endmodule
`default_nettype wire

// *** bench/mid_exec_tb.sv ***
// Self-checking bench for the step, skip, interrupt enable and indirect jump block
`timescale 1ns/1ps
`default_nettype none
`include "mid_map.svh"
module testbench;
  // ****************************************
  // Stimulus, observed outputs and tallies
  // ****************************************
  logic clk_sys = 1'b0; // 40 MHz core clock
  logic resetn = 1'b0; // Held low at start
  logic instr_valid = 1'b0;
  mid_pkg::mid_op_t instr_op = mid_pkg::MID_NOP_OP;
  logic instr_dest = 1'b0;
  logic [5:0] file_addr = 6'h15; // Fixed address, seen again on write-back
  logic [7:0] file_data = 8'h00;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata, file_wr_data, rd_val;
  logic [5:0] file_wr_addr;
  logic [9:0] pc_value;
  logic instr_ready, file_wr, fetch_discard, pc_load, global_irq_enable, null_flag;
  int fails = 0;
  int n_compared = 0;
  mid_exec dut (.clk_sys(clk_sys), .resetn(resetn), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_dest(instr_dest), .file_addr(file_addr), .file_data(file_data), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr_ready(instr_ready), .file_wr(file_wr), .file_wr_addr(file_wr_addr),
    .file_wr_data(file_wr_data), .fetch_discard(fetch_discard), .pc_load(pc_load),
    .pc_value(pc_value), .global_irq_enable(global_irq_enable), .null_flag(null_flag));
  // Half period of 12.5 ns
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  // Four-state compare, so an unknown never matches
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Byte results: data, register reads, write-back address
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk({2'h0, got}, {2'h0, exp});
  endtask
  // Single-bit results: pulses, levels and flags
  task automatic chk_flag(input logic got, input logic exp);
    chk({9'h000, got}, {9'h000, exp});
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One-cycle register write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read; data taken only in the following cycle
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
    chk_byte(rd_val, exp);
  endtask
  // Offer one operation; returns settled in the answer cycle
  task automatic do_op(input mid_pkg::mid_op_t op, input logic d, input logic [7:0] fd);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_dest <= d;
    file_data <= fd;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    #1;
  endtask
  // Step result: write pulse, its data, zero flag and readiness
  task automatic chk_step(input logic w, input logic [7:0] d, input logic z);
    chk_flag(file_wr, w);
    if (w) chk_byte(file_wr_data, d);
    if (w) chk_byte({2'h0, file_wr_addr}, 8'h15);
    chk_flag(null_flag, z);
    chk_flag(fetch_discard, 1'b0);
    chk_flag(instr_ready, 1'b1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_steps();
    rd(`MID_REG_WORKING, 8'h00); // Cleared by reset
    wr(`MID_REG_PC_LOW, 8'hff); // Read-only, ignored
    rd(`MID_REG_PC_LOW, 8'h00);
    rd(3'h6, 8'h00); // Unmapped reads as zero
    wr(`MID_REG_WORKING, 8'h5a); // Non-zero, so a lost result shows
    do_op(mid_pkg::MID_SUB_ONE_OP, 1'b0, 8'h01);
    chk_step(1'b0, 8'h00, 1'b1);
    rd(`MID_REG_WORKING, 8'h00);
    do_op(mid_pkg::MID_SUB_ONE_OP, 1'b1, 8'h00);
    chk_step(1'b1, 8'hff, 1'b0);
    do_op(mid_pkg::MID_ADD_ONE_OP, 1'b1, 8'hff);
    chk_step(1'b1, 8'h00, 1'b1);
    do_op(mid_pkg::MID_ADD_ONE_OP, 1'b0, 8'h7f);
    chk_step(1'b0, 8'h00, 1'b0);
    rd(`MID_REG_WORKING, 8'h80);
  endtask
  // Zero skip; a second offer and a status read ride the blocked cycle
  task automatic t_skip();
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_op <= mid_pkg::MID_ADD_ONE_SKIP_NULL_OP;
    instr_dest <= 1'b1;
    file_data <= 8'hff;
    @(posedge clk_sys);
    instr_op <= mid_pkg::MID_ADD_ONE_OP;
    reg_rd <= 1'b1;
    reg_addr <= `MID_REG_STATUS;
    #1 chk_flag(fetch_discard, 1'b1);
    chk_flag(file_wr, 1'b1);
    chk_byte(file_wr_data, 8'h00);
    chk_flag(instr_ready, 1'b0);
    chk_flag(null_flag, 1'b1);
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    reg_rd <= 1'b0;
    #1 chk_flag(instr_ready, 1'b1);
    chk_flag(file_wr, 1'b0);
    chk_flag(fetch_discard, 1'b0);
    chk_byte(reg_rdata, 8'h03);
    do_op(mid_pkg::MID_ADD_ONE_SKIP_NULL_OP, 1'b0, 8'h05);
    chk_step(1'b0, 8'h00, 1'b0);
    rd(`MID_REG_WORKING, 8'h06);
  endtask
  // Flag set first, so a flag that moves is caught
  task automatic t_irq();
    wr(`MID_REG_STATUS, 8'h01);
    rd(`MID_REG_STATUS, 8'h01); // Idle: busy bit clear
    do_op(mid_pkg::MID_IRQ_GLOBAL_ON_OP, 1'b0, 8'h00);
    chk_flag(global_irq_enable, 1'b1);
    chk_flag(instr_ready, 1'b1);
    chk_flag(null_flag, 1'b1);
    rd(`MID_REG_CONTROL, 8'h01);
    do_op(mid_pkg::MID_IRQ_GLOBAL_OFF_OP, 1'b0, 8'h00);
    chk_flag(global_irq_enable, 1'b0);
    chk_flag(instr_ready, 1'b1);
    chk_flag(null_flag, 1'b1);
    wr(`MID_REG_CONTROL, 8'h01); // Software path to the enable
    rd(`MID_REG_CONTROL, 8'h01);
  endtask
  task automatic t_jump();
    wr(`MID_REG_WORKING, 8'h34);
    wr(`MID_REG_TBL_HIGH, 8'hfe); // Upper bits must not reach the counter
    do_op(mid_pkg::MID_SUB_ONE_OP, 1'b1, 8'h01); // Zero flag set before the jump
    do_op(mid_pkg::MID_JUMP_VIA_WORKING_REG_OP, 1'b0, 8'h00);
    chk_flag(pc_load, 1'b1);
    chk(pc_value, 10'h234);
    chk_flag(instr_ready, 1'b0);
    chk_flag(null_flag, 1'b1);
    @(posedge clk_sys);
    #1 chk_flag(instr_ready, 1'b1);
    chk_flag(pc_load, 1'b0);
    rd(`MID_REG_PC_LOW, 8'h34);
    rd(`MID_REG_PC_HIGH, 8'h02);
  endtask
  // Mid-run reset: program counter, global enable, null flag, readiness, working register and table pointer back at rest
  task automatic t_reset();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk(pc_value, 10'h000);
    chk_flag(global_irq_enable, 1'b0);
    chk_flag(null_flag, 1'b0);
    chk_flag(instr_ready, 1'b1);
    rd(`MID_REG_WORKING, 8'h00);
    rd(`MID_REG_TBL_HIGH, 8'h00);
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    #1 chk_flag(instr_ready, 1'b1);
    chk_flag(global_irq_enable, 1'b0);
    chk(pc_value, 10'h000);
    t_steps();
    t_skip();
    t_irq();
    t_jump();
    t_reset();
    test_done();
  end
  // Whole run is under 200 cycles; 4000 means a hang
  initial begin
    repeat (4000) @(posedge clk_sys);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
